/* break_pkg.sv */
// shared constants and types for the breakpoint match unit
package break_pkg;
   typedef logic [31:0] word_t;

   localparam int NUM_LS_PORTS = 2;
   localparam int NUM_CMP      = 3;
   localparam int INSTR_CH     = 0;

   // instruction breakpoint control field layout
   localparam int ICTL_W          = 2;
   localparam int ICTL_ENABLE_BIT = 0;
   localparam int ICTL_SENSE_BIT  = 1;
   localparam logic [1:0] ICTL_RESET = 2'h0;

   // data breakpoint control field layout
   localparam int DCTL_W            = 6;
   localparam int DCTL_SEL_LSB      = 0;
   localparam int DCTL_SEL_MSB      = 1;
   localparam int DCTL_LOADS_BIT    = 2;
   localparam int DCTL_STORES_BIT   = 3;
   localparam int DCTL_ASENSE_BIT   = 4;
   localparam int DCTL_VSENSE_BIT   = 5;
   localparam logic [5:0] DCTL_RESET = 6'h00;

   // data break select encodings
   localparam logic [1:0] SEL_OFF   = 2'h0;
   localparam logic [1:0] SEL_ADDR  = 2'h1;
   localparam logic [1:0] SEL_VALUE = 2'h2;
   localparam logic [1:0] SEL_BOTH  = 2'h3;
endpackage

/* break_cmp_if.sv */
// carrier between the top and one comparator channel
`timescale 1ns/1ns
interface break_cmp_if;
   break_pkg::word_t low;
   break_pkg::word_t high;
   break_pkg::word_t addr;
   break_pkg::word_t word;
   break_pkg::word_t cmpWord;
   break_pkg::word_t mask;
   logic             rangeSense;
   logic             valueSense;
   logic             addrHit;
   logic             valueHit;

   modport user (
      output low, high, addr, word, cmpWord, mask, rangeSense, valueSense,
      input  addrHit, valueHit
   );
   modport unit (
      input  low, high, addr, word, cmpWord, mask, rangeSense, valueSense,
      output addrHit, valueHit
   );
endinterface

/* break_compare.sv */
// one range and masked value comparator channel
`timescale 1ns/1ns
module break_compare (
   break_cmp_if.unit cmp
);
   logic inRange;
   logic wordsEqual;

   // unsigned on full byte addresses, no aperture decode at all
   assign inRange = (cmp.addr >= cmp.low) &&
                    (cmp.addr <= cmp.high);
   assign cmp.addrHit = cmp.rangeSense ? !inRange : inRange;

   // all-zero mask always compares equal; software must avoid it
   assign wordsEqual = ((cmp.word ^ cmp.cmpWord) & cmp.mask) ==
                       32'h00000000;
   assign cmp.valueHit = cmp.valueSense ? !wordsEqual : wordsEqual;
endmodule

/* breakpoint_match_unit.sv */
// instruction and dual-port data breakpoint matcher with event outputs
`timescale 1ns/1ns
module breakpoint_match_unit (
   input  wire logic                          mclk,
   input  wire logic                          rst_n,
   input  wire logic                          instrCtlWe,
   input  wire logic [break_pkg::ICTL_W-1:0]  instrCtlWrData,
   input  wire logic                          instrLowWe,
   input  wire logic                          instrHighWe,
   input  wire logic                          dataCtlWe,
   input  wire logic [break_pkg::DCTL_W-1:0]  dataCtlWrData,
   input  wire logic                          dataLowWe,
   input  wire logic                          dataHighWe,
   input  wire logic                          dataValWe,
   input  wire logic                          dataMaskWe,
   input  wire logic [31:0]                   regWrData,
   input  wire logic                          instrValid,
   input  wire logic [31:0]                   instrAddr,
   input  wire logic [1:0]                    lsValid,
   input  wire logic [1:0]                    lsStore,
   input  wire logic [1:0][31:0]              lsAddr,
   input  wire logic [1:0][31:0]              lsData,
   output logic      [break_pkg::ICTL_W-1:0]  instrCtl,
   output logic      [break_pkg::DCTL_W-1:0]  dataCtl,
   output logic                               instrBreakEvent,
   output logic      [1:0]                    dataBreakEvent,
   output logic      [1:0]                    dataBreakCount
);
   // control registers, reset to defined values
   logic [break_pkg::ICTL_W-1:0] instrCtl_q;
   logic [break_pkg::ICTL_W-1:0] instrCtl_d;
   logic [break_pkg::DCTL_W-1:0] dataCtl_q;
   logic [break_pkg::DCTL_W-1:0] dataCtl_d;

   // compare operands, deliberately left without reset
   break_pkg::word_t instrLow_q;
   break_pkg::word_t instrLow_d;
   break_pkg::word_t instrHigh_q;
   break_pkg::word_t instrHigh_d;
   break_pkg::word_t dataLow_q;
   break_pkg::word_t dataLow_d;
   break_pkg::word_t dataHigh_q;
   break_pkg::word_t dataHigh_d;
   break_pkg::word_t dataVal_q;
   break_pkg::word_t dataVal_d;
   break_pkg::word_t dataMask_q;
   break_pkg::word_t dataMask_d;

   // event outputs
   logic       instrEvent_q;
   logic       instrEvent_d;
   logic [1:0] dataEvent_q;
   logic [1:0] dataEvent_d;
   logic [1:0] dataCount_q;
   logic [1:0] dataCount_d;

   // per-channel comparator results
   logic [break_pkg::NUM_CMP-1:0] addrHit;
   logic [break_pkg::NUM_CMP-1:0] valueHit;

   // decoded control fields
   logic       instrEnable;
   logic       instrSense;
   logic [1:0] dataSel;
   logic       breakLoads;
   logic       breakStores;
   logic       addrSense;
   logic       valueSense;

   assign instrEnable = instrCtl_q[break_pkg::ICTL_ENABLE_BIT];
   assign instrSense  = instrCtl_q[break_pkg::ICTL_SENSE_BIT];
   assign dataSel     = dataCtl_q[break_pkg::DCTL_SEL_MSB:
                                  break_pkg::DCTL_SEL_LSB];
   assign breakLoads  = dataCtl_q[break_pkg::DCTL_LOADS_BIT];
   assign breakStores = dataCtl_q[break_pkg::DCTL_STORES_BIT];
   assign addrSense   = dataCtl_q[break_pkg::DCTL_ASENSE_BIT];
   assign valueSense  = dataCtl_q[break_pkg::DCTL_VSENSE_BIT];

   // channel 0 watches fetch, channels 1..2 the load/store ports
   genvar gi;
   generate
      for (gi = 0; gi < break_pkg::NUM_CMP; gi++) begin : gCh
         break_cmp_if cmp ();

         if (gi == break_pkg::INSTR_CH) begin : gInstr
            assign cmp.low        = instrLow_q;
            assign cmp.high       = instrHigh_q;
            assign cmp.addr       = instrAddr;
            assign cmp.rangeSense = instrSense;
            // value path unused on fetch side
            assign cmp.word       = 32'h00000000;
            assign cmp.cmpWord    = 32'h00000000;
            assign cmp.mask       = 32'h00000000;
            assign cmp.valueSense = 1'b0;
         end else begin : gData
            assign cmp.low        = dataLow_q;
            assign cmp.high       = dataHigh_q;
            assign cmp.addr       = lsAddr[gi-1];
            assign cmp.rangeSense = addrSense;
            assign cmp.word       = lsData[gi-1];
            assign cmp.cmpWord    = dataVal_q;
            assign cmp.mask       = dataMask_q;
            assign cmp.valueSense = valueSense;
         end

         assign addrHit[gi]  = cmp.addrHit;
         assign valueHit[gi] = cmp.valueHit;

         break_compare uCmp (
            .cmp (cmp.unit)
         );
      end
   endgenerate

   // control register next state
   always_comb begin
      instrCtl_d = instrCtl_q;
      dataCtl_d  = dataCtl_q;
      if (!rst_n) begin
         instrCtl_d = break_pkg::ICTL_RESET;
         dataCtl_d  = break_pkg::DCTL_RESET;
      end else begin
         if (instrCtlWe) begin
            instrCtl_d = instrCtlWrData;
         end
         if (dataCtlWe) begin
            dataCtl_d = dataCtlWrData;
         end
      end
   end

   always_ff @(posedge mclk) begin
      instrCtl_q <= instrCtl_d;
      dataCtl_q  <= dataCtl_d;
   end

   // operand registers: written only by software, reset leaves them as is
   always_comb begin
      instrLow_d  = instrLowWe  ? regWrData : instrLow_q;
      instrHigh_d = instrHighWe ? regWrData : instrHigh_q;
      dataLow_d   = dataLowWe   ? regWrData : dataLow_q;
      dataHigh_d  = dataHighWe  ? regWrData : dataHigh_q;
      dataVal_d   = dataValWe   ? regWrData : dataVal_q;
      dataMask_d  = dataMaskWe  ? regWrData : dataMask_q;
   end

   always_ff @(posedge mclk) begin
      instrLow_q  <= instrLow_d;
      instrHigh_q <= instrHigh_d;
      dataLow_q   <= dataLow_d;
      dataHigh_q  <= dataHigh_d;
      dataVal_q   <= dataVal_d;
      dataMask_q  <= dataMask_d;
   end

   // event generation, one cycle after the access is presented
   logic [1:0] portOn;
   logic [1:0] portHit;

   always_comb begin
      portOn  = 2'h0;
      portHit = 2'h0;
      // both ports are judged in parallel, never serialised
      for (int p = 0; p < break_pkg::NUM_LS_PORTS; p++) begin
         portOn[p] = lsValid[p] &&
                     (lsStore[p] ? breakStores : breakLoads);
         case (dataSel)
            break_pkg::SEL_OFF: begin
               portHit[p] = 1'b0;
            end
            break_pkg::SEL_ADDR: begin
               portHit[p] = portOn[p] && addrHit[p+1];
            end
            break_pkg::SEL_VALUE: begin
               portHit[p] = portOn[p] && valueHit[p+1];
            end
            break_pkg::SEL_BOTH: begin
               portHit[p] = portOn[p] && addrHit[p+1] &&
                            valueHit[p+1];
            end
            default: begin
               portHit[p] = 1'b0;
            end
         endcase
      end

      if (!rst_n) begin
         instrEvent_d = 1'b0;
         dataEvent_d  = 2'h0;
         dataCount_d  = 2'h0;
      end else begin
         instrEvent_d = instrEnable && instrValid &&
                        addrHit[break_pkg::INSTR_CH];
         dataEvent_d  = portHit;
         // timer on this source adds the count, so it may step by two
         dataCount_d  = {1'b0, portHit[0]} + {1'b0, portHit[1]};
      end
   end

   always_ff @(posedge mclk) begin
      instrEvent_q <= instrEvent_d;
      dataEvent_q  <= dataEvent_d;
      dataCount_q  <= dataCount_d;
   end

   assign instrCtl        = instrCtl_q;
   assign dataCtl         = dataCtl_q;
   assign instrBreakEvent = instrEvent_q;
   assign dataBreakEvent  = dataEvent_q;
   assign dataBreakCount  = dataCount_q;

   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_instr_ctl_reset:
   assert property (!$past(rst_n) |-> instrCtl == 2'h0)
      else $error("instruction control not cleared by reset");

   a_data_ctl_reset:
   assert property (!$past(rst_n) |-> dataCtl == 6'h00)
      else $error("data control not cleared by reset");

   a_instr_disabled:
   assert property (!instrEnable |=> !instrBreakEvent)
      else $error("instruction event while disabled");

   a_instr_inside:
   assert property (instrEnable && !instrSense && instrValid &&
                    instrAddr >= instrLow_q && instrAddr <= instrHigh_q
                    |=> instrBreakEvent)
      else $error("missed inside instruction match");

   a_instr_outside:
   assert property (instrEnable && instrSense && instrValid &&
                    (instrAddr < instrLow_q || instrAddr > instrHigh_q)
                    |=> instrBreakEvent)
      else $error("missed outside instruction match");

   a_data_off:
   assert property (dataSel == 2'h0 |=> dataBreakEvent == 2'h0)
      else $error("data event while select is zero");

   a_load_gate:
   assert property (lsValid[0] && !lsStore[0] && !breakLoads
                    |=> !dataBreakEvent[0])
      else $error("load event with loads not enabled");

   a_value_equal:
   assert property (dataSel == 2'h2 && !valueSense && lsValid[1] &&
                    lsStore[1] && breakStores &&
                    ((lsData[1] ^ dataVal_q) & dataMask_q) == 32'h0
                    |=> dataBreakEvent[1])
      else $error("missed masked value match on port 1");

   a_both_needed:
   assert property (dataSel == 2'h3 && !addrHit[1] |=> !dataBreakEvent[0])
      else $error("combined mode fired without address match");

   a_count_sum:
   assert property (dataBreakCount ==
                    {1'b0, dataBreakEvent[0]} + {1'b0, dataBreakEvent[1]})
      else $error("event count disagrees with events");

   a_instr_idle:
   assert property (!instrValid |=> !instrBreakEvent)
      else $error("instruction event without issued address");

   a_instr_in_miss:
   assert property (instrEnable && !instrSense && instrValid &&
                    (instrAddr < instrLow_q || instrAddr > instrHigh_q)
                    |=> !instrBreakEvent)
      else $error("inside instruction match outside the range");

   a_instr_out_miss:
   assert property (instrEnable && instrSense && instrValid &&
                    instrAddr >= instrLow_q && instrAddr <= instrHigh_q
                    |=> !instrBreakEvent)
      else $error("outside instruction match inside the range");

   a_instr_reg_hold:
   assert property (!instrLowWe && !instrHighWe |=>
                    $stable(instrLow_q) && $stable(instrHigh_q))
      else $error("instruction range changed without a write");

   a_data_reg_hold:
   assert property (!dataLowWe && !dataHighWe && !dataValWe && !dataMaskWe
                    |=> $stable(dataLow_q) && $stable(dataHigh_q) &&
                        $stable(dataVal_q) && $stable(dataMask_q))
      else $error("data operand changed without a write");

   a_store_gate:
   assert property (lsValid[1] && lsStore[1] && !breakStores
                    |=> !dataBreakEvent[1])
      else $error("store event with stores not enabled");

   a_port_idle:
   assert property (!lsValid[0] |=> !dataBreakEvent[0])
      else $error("data event on an idle port");

   a_data_inside:
   assert property (dataSel == break_pkg::SEL_ADDR && !addrSense &&
                    lsValid[0] && !lsStore[0] && breakLoads &&
                    lsAddr[0] >= dataLow_q && lsAddr[0] <= dataHigh_q
                    |=> dataBreakEvent[0])
      else $error("missed inside data address match on port 0");

   a_data_outside:
   assert property (dataSel == break_pkg::SEL_ADDR && addrSense &&
                    lsValid[1] && lsStore[1] && breakStores &&
                    (lsAddr[1] < dataLow_q || lsAddr[1] > dataHigh_q)
                    |=> dataBreakEvent[1])
      else $error("missed outside data address match on port 1");

   a_value_differ:
   assert property (dataSel == break_pkg::SEL_VALUE && valueSense &&
                    lsValid[0] && !lsStore[0] && breakLoads &&
                    ((lsData[0] ^ dataVal_q) & dataMask_q) != 32'h00000000
                    |=> dataBreakEvent[0])
      else $error("missed masked value difference on port 0");

   a_both_match:
   assert property (dataSel == break_pkg::SEL_BOTH && !addrSense &&
                    !valueSense && lsValid[1] && !lsStore[1] && breakLoads &&
                    lsAddr[1] >= dataLow_q && lsAddr[1] <= dataHigh_q &&
                    ((lsData[1] ^ dataVal_q) & dataMask_q) == 32'h00000000
                    |=> dataBreakEvent[1])
      else $error("missed combined match on port 1");

   a_dual_event:
   assert property (dataSel == break_pkg::SEL_ADDR && addrSense &&
                    lsValid == 2'h3 && breakLoads && breakStores &&
                    (lsAddr[0] < dataLow_q || lsAddr[0] > dataHigh_q) &&
                    (lsAddr[1] < dataLow_q || lsAddr[1] > dataHigh_q)
                    |=> dataBreakCount == 2'h2)
      else $error("two port matches not counted as two");
endmodule

/* event_timer.sv */
// event-counting timer model fed by the breakpoint events
`timescale 1ns/1ns
module event_timer #(
   parameter int MODULUS = 5
) (
   input  wire logic       mclk,
   input  wire logic       instrEvent,
   input  wire logic [1:0] dataCount,
   output int              instrTotal,
   output int              dataTotal,
   output int              irqCount
);
   int value;
   initial begin
      {instrTotal, dataTotal, irqCount, value} = '0;
   end
   // a data source may add two in one cycle, so wrap by subtraction
   always @(posedge mclk) begin
      instrTotal <= instrTotal + int'(instrEvent);
      dataTotal <= dataTotal + int'(dataCount);
      if (value + int'(dataCount) >= MODULUS) begin
         value <= value + int'(dataCount) - MODULUS;
         irqCount <= irqCount + 1;
      end else begin
         value <= value + int'(dataCount);
      end
   end
endmodule

/* tb_top.sv */
// self-checking bench for the breakpoint match unit
`timescale 1ns/1ns
module tb_top;
   logic             mclk = 0, rst_n = 0, instrValid = 0, instrBreakEvent;
   logic             instrCtlWe = 0, instrLowWe = 0, instrHighWe = 0;
   logic             dataCtlWe = 0, dataLowWe = 0, dataHighWe = 0;
   logic             dataValWe = 0, dataMaskWe = 0;
   logic [1:0]       instrCtlWrData = 0, lsValid = 0, lsStore = 0;
   logic [1:0]       instrCtl, dataBreakEvent, dataBreakCount;
   logic [5:0]       dataCtlWrData = 0, dataCtl;
   logic [31:0]      regWrData = 0, instrAddr = 0;
   logic [1:0][31:0] lsAddr = '0, lsData = '0;
   logic [1:0]       mIc = 0;
   logic [5:0]       mDc = 0;
   logic [31:0]      mIlo = 0, mIhi = 0, mDlo = 0, mDhi = 0;
   logic [31:0]      mVal = 0, mMask = 0;
   int               instrTotal, dataTotal, irqCount, expI = 0, expD = 0;
   int               nErrors = 0, nChecks = 0, seed = 32'h3A1647C1;

   always #4 mclk = ~mclk;

   breakpoint_match_unit i_dut (.mclk, .rst_n,
      .instrCtlWe, .instrCtlWrData, .instrLowWe, .instrHighWe, .dataCtlWe,
      .dataCtlWrData, .dataLowWe, .dataHighWe, .dataValWe, .dataMaskWe,
      .regWrData, .instrValid, .instrAddr, .lsValid, .lsStore, .lsAddr,
      .lsData, .instrCtl, .dataCtl, .instrBreakEvent, .dataBreakEvent,
      .dataBreakCount);
   event_timer #(.MODULUS(5)) i_timer (.mclk, .instrEvent(instrBreakEvent),
      .dataCount(dataBreakCount), .instrTotal, .dataTotal, .irqCount);

   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      nChecks++;
      if (got !== exp) begin
         nErrors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", nChecks, nErrors);
      if (nErrors == 0 && nChecks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // boundary neighbours hit the inclusive ends and the wrap at zero
   function automatic logic [31:0] near(logic [31:0] lo, logic [31:0] hi);
      int r;
      r = $random(seed);
      case (r & 3)
         0: return lo - 32'(r[2]);
         1: return hi + 32'(r[2]);
         default: return $random(seed);
      endcase
   endfunction

   function automatic bit portHit(int p);
      bit en, aHit, vHit;
      en = mDc[1:0] != 0 && lsValid[p] && (lsStore[p] ? mDc[3] : mDc[2]);
      aHit = ((mDlo <= lsAddr[p]) && (lsAddr[p] <= mDhi)) ^ mDc[4];
      vHit = ((lsData[p] & mMask) == (mVal & mMask)) ^ mDc[5];
      if (mDc[1:0] == 1) return en && aHit;
      if (mDc[1:0] == 2) return en && vHit;
      return en && aHit && vHit;
   endfunction

   task automatic drive_access();
      instrValid = $random(seed);
      instrAddr = near(mIlo, mIhi);
      lsValid = $random(seed);
      lsStore = $random(seed);
      for (int p = 0; p < 2; p++) begin
         lsAddr[p] = near(mDlo, mDhi);
         lsData[p] = ($random(seed) & 1) ? mVal ^ ($random(seed) & ~mMask)
                                         : $random(seed);
      end
   endtask

   // the expectation uses the settings from before this cycle's writes
   task automatic step();
      bit ei;
      bit [1:0] ed;
      ei = 0;
      ed = 0;
      if (rst_n) begin
         ei = mIc[0] && instrValid
              && (((mIlo <= instrAddr) && (instrAddr <= mIhi)) ^ mIc[1]);
         ed = {portHit(1), portHit(0)};
         if (instrCtlWe) mIc = instrCtlWrData;
         if (dataCtlWe) mDc = dataCtlWrData;
      end else begin
         mIc = 0;
         mDc = 0;
      end
      if (instrLowWe) mIlo = regWrData;
      if (instrHighWe) mIhi = regWrData;
      if (dataLowWe) mDlo = regWrData;
      if (dataHighWe) mDhi = regWrData;
      if (dataValWe) mVal = regWrData;
      if (dataMaskWe) mMask = regWrData;
      expI += ei;
      expD += ed[0] + ed[1];
      @(posedge mclk);
      #1;
      chk("instrCtl", mIc, instrCtl);
      chk("dataCtl", mDc, dataCtl);
      chk("instrBreakEvent", ei, instrBreakEvent);
      chk("dataBreakEvent", ed, dataBreakEvent);
      chk("dataBreakCount", 32'(ed[0]) + ed[1], dataBreakCount);
   endtask

   initial begin
      // refused control writes, operand writes that still take
      {instrCtlWe, dataCtlWe, instrCtlWrData, dataCtlWrData} = 10'h3FF;
      {instrLowWe, instrHighWe, dataLowWe, dataHighWe} = 4'hF;
      {dataValWe, dataMaskWe} = 2'h3;
      for (int i = 0; i < 10; i++) step();
      rst_n = 1;
      for (int c = 0; c < 256; c++) begin
         for (int k = 0; k < 8; k++) begin
            {instrCtlWe, dataCtlWe} = {2{k == 0}};
            {instrCtlWrData, dataCtlWrData} = c[7:0];
            {instrLowWe, dataLowWe} = {2{k == 0}};
            {instrHighWe, dataHighWe} = {2{k == 1}};
            dataValWe = k == 2;
            dataMaskWe = k == 3;
            regWrData = $random(seed) | 32'(k == 3);
            rst_n = !(c == 100 && k == 5);
            drive_access();
            step();
         end
      end
      $display("test configuration sweep done");
      {lsValid, instrValid} = 0;
      step();
      chk("instrTotal", expI, instrTotal);
      chk("dataTotal", expD, dataTotal);
      chk("irqCount", expD / 5, irqCount);
      $display("test timer counting done");
      report_and_stop();
   end

   initial begin
      #100000;
      nErrors++;
      report_and_stop();
   end
endmodule
